// ---- hw/sefc_defs.vh ----
/*
  Register offsets, field positions, reset values and timing counts for
  the switch event and forwarding control block.
  Assumes one 100 MHz switch clock and byte-wide registers.
*/
`ifndef SEFC_DEFS_VH
`define SEFC_DEFS_VH

`define SEFC_ADDR_INT_FLAGS 8'h7C
`define SEFC_ADDR_INT_MASK 8'h7D
`define SEFC_ADDR_RF_FLAGS 8'h7E
`define SEFC_ADDR_RF_ENABLE 8'h7F
`define SEFC_ADDR_PRIO_LOW 8'h80
`define SEFC_ADDR_PRIO_HIGH 8'h81
`define SEFC_ADDR_SPLIT 8'h82
`define SEFC_ADDR_UUC_FWD 8'h83
`define SEFC_ADDR_UMC_FWD 8'h84
`define SEFC_ADDR_UVID_FWD 8'h85
`define SEFC_ADDR_SELF_IPMC 8'h86
`define SEFC_ADDR_RATE_CFG 8'h87
`define SEFC_ADDR_MAC0 8'h68
`define SEFC_ADDR_MAC5 8'h6D

`define SEFC_RST_PRIO_LOW 8'h50
`define SEFC_RST_PRIO_HIGH 8'hFA
`define SEFC_RST_SPLIT 2'h2
`define SEFC_RST_SPLIT_RSVD 6'h08
`define SEFC_RST_UUC_RSVD 2'h2
`define SEFC_RST_UMC_RSVD 2'h1
`define SEFC_RST_RATE_SEL 2'h1
`define SEFC_RST_MAC 48'h0010A1FFFFFF

`define SEFC_BIT_POWER 4
`define SEFC_BIT_FWD_EN 5
`define SEFC_BIT_SELF_EN 6
`define SEFC_SPLIT_MSB 7
`define SEFC_SPLIT_LSB 6
`define SEFC_RATE_MSB 5
`define SEFC_RATE_LSB 4
`define SEFC_SYNC_WARM 2'h3

`define SEFC_SPLIT_RES012_LOW 2'h0
`define SEFC_SPLIT_RES01_LOW 2'h2
`define SEFC_SPLIT_RES0_LOW 2'h3
`define SEFC_RES_LOWEST 2'h0
`define SEFC_RES_HIGHEST 2'h3
`define SEFC_RES_ONE 2'h1

`define SEFC_CLK_MHZ 100
`define SEFC_PERIOD_16_MS 16
`define SEFC_PERIOD_64_MS 64
`define SEFC_PERIOD_256_MS 256
`define SEFC_CYC_PER_MS (`SEFC_CLK_MHZ * 1000)

`endif

// ---- hw/sefc_fwd_map.v ----
/*
  One unknown-frame forwarding selector: enable plus five-bit port mask.
  Assumes the classifier holds frame_hit for one cycle per frame.
*/
`include "sefc_defs.vh"

module sefc_fwd_map (
  input wire clk,
  input wire sys_rst,
  input wire fwd_enable,
  input wire [4:0] port_map,
  input wire frame_hit,
  output reg [4:0] dest_ports,
  output reg frame_drop
);
  // Bit n of the map selects port n+1; any combination is honoured [RULE17]
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dest_ports <= 5'h00;
      frame_drop <= 1'b0;
    end else begin
      dest_ports <= (frame_hit && fwd_enable) ? port_map : 5'h00; // [RULE10] [RULE11]
      // A zero map or a cleared enable discards the frame [RULE10]
      frame_drop <= frame_hit && (!fwd_enable || (port_map == 5'h00));
    end
  end
endmodule

// ---- hw/sefc_period_timer.v ----
/*
  Ingress rate-limit unit period tick generator.
  Assumes a 100 MHz clock; period counts are parameters so benches can shorten them.
*/
`include "sefc_defs.vh"

module sefc_period_timer #(
  parameter [31:0] CYC_16 = `SEFC_PERIOD_16_MS * `SEFC_CYC_PER_MS,
  parameter [31:0] CYC_64 = `SEFC_PERIOD_64_MS * `SEFC_CYC_PER_MS,
  parameter [31:0] CYC_256 = `SEFC_PERIOD_256_MS * `SEFC_CYC_PER_MS
) (
  input wire clk,
  input wire sys_rst,
  input wire [1:0] period_sel,
  output reg period_tick
);
  reg [31:0] count;
  wire [31:0] limit;

  // 00 is 16 ms, 01 is 64 ms, 1x is 256 ms [RULE16]
  assign limit = period_sel[1] ? CYC_256 : (period_sel[0] ? CYC_64 : CYC_16);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 32'h00000000;
      period_tick <= 1'b0;
    end else if (count >= limit - 32'h00000001) begin
      // >= so a shortened period after a reselect ends at once
      count <= 32'h00000000;
      period_tick <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      period_tick <= 1'b0;
    end
  end
endmodule

// ---- hw/sefc_top.v ----
/*
  Register bank of the switch event and forwarding control block.
  Assumes a byte register port fed by the serial management slave in
  the switch clock domain; link, power and rule-filter events are pins.
*/
// Function
// RULE1: Port flags latch on link change, stay set until one written.
// RULE2: Mask bits: power in bit 4, ports in 3..0; one enables; reset zero.
// RULE3: Interrupt request active while any flag is set with its mask bit.
// RULE4: Read-only five-bit rule-filter event field, one bit per port.
// RULE5: Writable five-bit rule-filter interrupt enable, reset zero.
// RULE6: Each of eight tag priorities maps to a programmable 2-bit queue.
// RULE7: Queue three is highest priority, queue zero lowest.
// RULE8: Two-queue fold: result 0 low, 3 high, 1 and 2 by split select.
// RULE9: Split 00: 0-2 low; 10: 0-1 low; 11: only 0 low; 01 forbidden.
// RULE10: Unknown unicast goes to the port map when enabled; 00000 discards.
// RULE11: Map 00001 port one, 00011 ports one-two, 11111 all ports.
// RULE12: Unknown non-IP multicast uses its own enable and port map.
// RULE13: Unknown VLAN ID frames use enable and map; 00000 drops, 11111 floods.
// RULE14: Unknown IP multicast uses its own enable and map, reset zero.
// RULE15: Self-address filter enable bit 6 drops frames with own MAC.
// RULE16: Rate period field: 00 16 ms, 01 64 ms (reset), 1x 256 ms.
// RULE17: Port map bit n selects port n+1; every combination honoured.
// RULE18: Power flag in bit 4 set by power event, cleared by writing one.
// RULE19: Own 48-bit MAC address held in six byte registers.
// RULE20: Software leaves reserved fields at their reset values.
`include "sefc_defs.vh"

module sefc_top #(
  parameter [31:0] CYC_16 = `SEFC_PERIOD_16_MS * `SEFC_CYC_PER_MS,
  parameter [31:0] CYC_64 = `SEFC_PERIOD_64_MS * `SEFC_CYC_PER_MS,
  parameter [31:0] CYC_256 = `SEFC_PERIOD_256_MS * `SEFC_CYC_PER_MS
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire [3:0] link_change,
  input wire power_event,
  input wire [4:0] rule_filter_hit,
  input wire [2:0] vlan_prio,
  input wire prio_valid,
  input wire [47:0] frame_da,
  input wire [47:0] frame_sa,
  input wire frame_valid,
  input wire uuc_hit,
  input wire umc_hit,
  input wire uvid_hit,
  input wire ipmc_hit,
  output reg irq,
  output reg rule_filter_irq,
  output reg [1:0] queue_4q,
  output reg queue_2q_high,
  output reg self_drop,
  output reg [4:0] uuc_ports,
  output reg uuc_drop,
  output reg [4:0] umc_ports,
  output reg umc_drop,
  output reg [4:0] uvid_ports,
  output reg uvid_drop,
  output reg [4:0] ipmc_ports,
  output reg ipmc_drop,
  output reg rate_period_tick
);

  // Pin inputs from outside the clock domain: two-stage synchronisers
  reg [3:0] link_s1;
  reg [3:0] link_s2;
  reg [3:0] link_s3;
  reg pwr_s1;
  reg pwr_s2;
  reg pwr_s3;
  reg [4:0] rf_s1;
  reg [4:0] rf_s2;
  // Link edges are ignored until the delay line holds real pin levels,
  // so a port that is already up at reset raises no false flag
  reg [1:0] sync_warm;

  // Register state
  reg [4:0] int_flags;
  reg [4:0] int_mask;
  reg [4:0] rule_filter_event_bits;
  reg [4:0] rule_filter_event_enables;
  reg [7:0] tag_priority_map_low;
  reg [7:0] tag_priority_map_high;
  reg [1:0] two_queue_split_select;
  reg uuc_en;
  reg umc_en;
  reg uvid_en;
  reg ipmc_en;
  reg self_en;
  reg [4:0] uuc_map;
  reg [4:0] umc_map;
  reg [4:0] uvid_map;
  reg [4:0] ipmc_map;
  reg [1:0] rate_sel;
  reg [47:0] own_mac;

  wire wr_flags = reg_write && (reg_addr == `SEFC_ADDR_INT_FLAGS);
  wire sync_ready = (sync_warm == `SEFC_SYNC_WARM);
  wire [3:0] link_edge = sync_ready ? (link_s2 ^ link_s3) : 4'h0;
  wire pwr_rise = pwr_s2 && !pwr_s3;
  wire [4:0] flag_set = {pwr_rise, link_edge};
  wire [4:0] flag_clr = wr_flags ? reg_wdata[4:0] : 5'h00;
  wire [4:0] next_int_flags = (int_flags & ~flag_clr) | flag_set;
  wire [15:0] prio_map = {tag_priority_map_high, tag_priority_map_low};
  wire [1:0] mapped_q = prio_map[{vlan_prio, 1'b0} +: 2];
  wire [4:0] fwd_dest [0:3];
  wire [3:0] fwd_drop;
  wire tick;
  reg next_high;
  reg [7:0] next_rdata;
  integer i;
  integer j;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_s1 <= 4'h0;
      link_s2 <= 4'h0;
      link_s3 <= 4'h0;
      pwr_s1 <= 1'b0;
      pwr_s2 <= 1'b0;
      pwr_s3 <= 1'b0;
      rf_s1 <= 5'h00;
      rf_s2 <= 5'h00;
      sync_warm <= 2'h0;
    end else begin
      // A power event already high at reset still counts as a rise
      if (sync_warm != `SEFC_SYNC_WARM) begin
        sync_warm <= sync_warm + 2'h1;
      end
      link_s1 <= link_change;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
      pwr_s1 <= power_event;
      pwr_s2 <= pwr_s1;
      pwr_s3 <= pwr_s2;
      rf_s1 <= rule_filter_hit;
      rf_s2 <= rf_s1;
    end
  end

  // Event flags: a set in the same cycle as a write-one clear wins
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_flags <= 5'h00;
      rule_filter_event_bits <= 5'h00;
    end else begin
      int_flags <= next_int_flags; // [RULE1] [RULE18]
      // Read-only per-port event indication, follows the filter engine [RULE4]
      rule_filter_event_bits <= rf_s2;
    end
  end

  // Writable configuration; reserved bits are not stored [RULE20]
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_mask <= 5'h00;
      rule_filter_event_enables <= 5'h00;
      tag_priority_map_low <= `SEFC_RST_PRIO_LOW;
      tag_priority_map_high <= `SEFC_RST_PRIO_HIGH;
      two_queue_split_select <= `SEFC_RST_SPLIT;
      uuc_en <= 1'b0;
      uuc_map <= 5'h00;
      umc_en <= 1'b0;
      umc_map <= 5'h00;
      uvid_en <= 1'b0;
      uvid_map <= 5'h00;
      self_en <= 1'b0;
      ipmc_en <= 1'b0;
      ipmc_map <= 5'h00;
      rate_sel <= `SEFC_RST_RATE_SEL;
      own_mac <= `SEFC_RST_MAC;
    end else if (reg_write) begin
      case (reg_addr)
        `SEFC_ADDR_INT_MASK: int_mask <= reg_wdata[4:0]; // [RULE2]
        `SEFC_ADDR_RF_ENABLE: rule_filter_event_enables <= reg_wdata[4:0]; // [RULE5]
        `SEFC_ADDR_PRIO_LOW: tag_priority_map_low <= reg_wdata; // [RULE6]
        `SEFC_ADDR_PRIO_HIGH: tag_priority_map_high <= reg_wdata; // [RULE6]
        `SEFC_ADDR_SPLIT: begin
          two_queue_split_select <= reg_wdata[`SEFC_SPLIT_MSB:`SEFC_SPLIT_LSB];
        end
        `SEFC_ADDR_UUC_FWD: begin
          uuc_en <= reg_wdata[`SEFC_BIT_FWD_EN];
          uuc_map <= reg_wdata[4:0];
        end
        `SEFC_ADDR_UMC_FWD: begin
          umc_en <= reg_wdata[`SEFC_BIT_FWD_EN]; // [RULE12]
          umc_map <= reg_wdata[4:0];
        end
        `SEFC_ADDR_UVID_FWD: begin
          uvid_en <= reg_wdata[`SEFC_BIT_FWD_EN]; // [RULE13]
          uvid_map <= reg_wdata[4:0];
        end
        `SEFC_ADDR_SELF_IPMC: begin
          self_en <= reg_wdata[`SEFC_BIT_SELF_EN]; // [RULE15]
          ipmc_en <= reg_wdata[`SEFC_BIT_FWD_EN]; // [RULE14]
          ipmc_map <= reg_wdata[4:0];
        end
        `SEFC_ADDR_RATE_CFG: begin
          rate_sel <= reg_wdata[`SEFC_RATE_MSB:`SEFC_RATE_LSB]; // [RULE16]
        end
        default: begin
          // Six MAC bytes, most significant at the lowest address [RULE19]
          for (i = 0; i < 6; i = i + 1) begin
            if (reg_addr == `SEFC_ADDR_MAC0 + i[7:0]) begin
              own_mac[(5 - i) * 8 +: 8] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `SEFC_ADDR_INT_FLAGS: next_rdata = {3'h0, int_flags};
      `SEFC_ADDR_INT_MASK: next_rdata = {3'h0, int_mask};
      `SEFC_ADDR_RF_FLAGS: next_rdata = {3'h0, rule_filter_event_bits}; // [RULE4]
      `SEFC_ADDR_RF_ENABLE: next_rdata = {3'h0, rule_filter_event_enables};
      `SEFC_ADDR_PRIO_LOW: next_rdata = tag_priority_map_low;
      `SEFC_ADDR_PRIO_HIGH: next_rdata = tag_priority_map_high;
      `SEFC_ADDR_SPLIT: next_rdata = {two_queue_split_select, `SEFC_RST_SPLIT_RSVD};
      `SEFC_ADDR_UUC_FWD: next_rdata = {`SEFC_RST_UUC_RSVD, uuc_en, uuc_map};
      `SEFC_ADDR_UMC_FWD: next_rdata = {`SEFC_RST_UMC_RSVD, umc_en, umc_map};
      `SEFC_ADDR_UVID_FWD: next_rdata = {2'h0, uvid_en, uvid_map};
      `SEFC_ADDR_SELF_IPMC: next_rdata = {1'b0, self_en, ipmc_en, ipmc_map};
      `SEFC_ADDR_RATE_CFG: next_rdata = {2'h0, rate_sel, 4'h0};
      default: begin
        for (j = 0; j < 6; j = j + 1) begin
          if (reg_addr == `SEFC_ADDR_MAC0 + j[7:0]) begin
            next_rdata = own_mac[(5 - j) * 8 +: 8];
          end
        end
      end
    endcase
  end

  // Two-queue fold of the 2-bit result
  always @* begin
    case (mapped_q)
      `SEFC_RES_LOWEST: next_high = 1'b0; // [RULE8]
      `SEFC_RES_HIGHEST: next_high = 1'b1; // [RULE8]
      default: begin
        // Split 01 is not allowed; it is decoded like 10 as a safe fallback
        case (two_queue_split_select)
          `SEFC_SPLIT_RES012_LOW: next_high = 1'b0; // [RULE9]
          `SEFC_SPLIT_RES0_LOW: next_high = 1'b1; // [RULE9]
          default: next_high = (mapped_q != `SEFC_RES_ONE); // [RULE9]
        endcase
      end
    endcase
  end

  // Output registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      rule_filter_irq <= 1'b0;
      queue_4q <= 2'h0;
      queue_2q_high <= 1'b0;
      self_drop <= 1'b0;
      rate_period_tick <= 1'b0;
    end else begin
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
      irq <= |(next_int_flags & int_mask); // [RULE3]
      rule_filter_irq <= |(rf_s2 & rule_filter_event_enables); // [RULE5]
      if (prio_valid) begin
        // Higher code is the more urgent egress queue [RULE7]
        queue_4q <= mapped_q; // [RULE6]
        queue_2q_high <= next_high;
      end
      // Own address as source or destination is dropped at egress [RULE15]
      self_drop <= frame_valid && self_en &&
                   ((frame_da == own_mac) || (frame_sa == own_mac));
      rate_period_tick <= tick;
    end
  end

  always @* begin
    uuc_ports = fwd_dest[0];
    umc_ports = fwd_dest[1];
    uvid_ports = fwd_dest[2];
    ipmc_ports = fwd_dest[3];
    {ipmc_drop, uvid_drop, umc_drop, uuc_drop} = fwd_drop;
  end

  sefc_fwd_map u_uuc ( // [RULE10]
    .clk(clk),
    .sys_rst(sys_rst),
    .fwd_enable(uuc_en),
    .port_map(uuc_map),
    .frame_hit(uuc_hit),
    .dest_ports(fwd_dest[0]),
    .frame_drop(fwd_drop[0])
  );

  sefc_fwd_map u_umc ( // [RULE12]
    .clk(clk),
    .sys_rst(sys_rst),
    .fwd_enable(umc_en),
    .port_map(umc_map),
    .frame_hit(umc_hit),
    .dest_ports(fwd_dest[1]),
    .frame_drop(fwd_drop[1])
  );

  sefc_fwd_map u_uvid ( // [RULE13]
    .clk(clk),
    .sys_rst(sys_rst),
    .fwd_enable(uvid_en),
    .port_map(uvid_map),
    .frame_hit(uvid_hit),
    .dest_ports(fwd_dest[2]),
    .frame_drop(fwd_drop[2])
  );

  sefc_fwd_map u_ipmc ( // [RULE14]
    .clk(clk),
    .sys_rst(sys_rst),
    .fwd_enable(ipmc_en),
    .port_map(ipmc_map),
    .frame_hit(ipmc_hit),
    .dest_ports(fwd_dest[3]),
    .frame_drop(fwd_drop[3])
  );

  sefc_period_timer #(
    .CYC_16(CYC_16),
    .CYC_64(CYC_64),
    .CYC_256(CYC_256)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .period_sel(rate_sel),
    .period_tick(tick)
  );
endmodule

// ---- test/sefc_top_properties.sv ----
/*
  Port-level checks on the event and forwarding control register bank.
  Assumes it is bound to sefc_top and sees only that module's ports.
*/
module sefc_top_properties (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire prio_valid,
  input wire frame_valid,
  input wire uuc_hit,
  input wire irq,
  input wire [1:0] queue_4q,
  input wire queue_2q_high,
  input wire self_drop,
  input wire [4:0] uuc_ports,
  input wire uuc_drop,
  input wire [4:0] umc_ports,
  input wire umc_drop,
  input wire [4:0] uvid_ports,
  input wire uvid_drop,
  input wire [4:0] ipmc_ports,
  input wire ipmc_drop,
  input wire rate_period_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_uuc_outcome: assert property (uuc_hit |=> uuc_drop == (uuc_ports == 5'h00))
    else $error("Unicast outcome wrong");
  a_umc_drop_empty: assert property (umc_drop |-> umc_ports == 5'h00)
    else $error("Multicast drop with ports");
  a_uvid_drop_empty: assert property (uvid_drop |-> uvid_ports == 5'h00)
    else $error("VLAN drop with ports");
  a_ipmc_drop_empty: assert property (ipmc_drop |-> ipmc_ports == 5'h00)
    else $error("IP multicast drop with ports");
  // Mask cleared means no request may remain a few edges later
  a_irq_mask_off: assert property (
    reg_write && reg_addr == 8'h7D && reg_wdata == 8'h00 |-> ##3 !irq)
    else $error("Request with all masks off");
  a_self_drop_cause: assert property (self_drop |-> $past(frame_valid))
    else $error("Self drop without frame");
  a_queue_hold: assert property (
    !prio_valid |=> $stable(queue_4q) && $stable(queue_2q_high))
    else $error("Queue moved without request");
  a_fold_top: assert property (queue_4q == 2'h3 |-> queue_2q_high)
    else $error("Result three not high");
  a_tick_pulse: assert property (rate_period_tick |=> !rate_period_tick [*3])
    else $error("Period tick too close");
endmodule

bind sefc_top sefc_top_properties chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
  .prio_valid, .frame_valid, .uuc_hit, .irq, .queue_4q, .queue_2q_high, .self_drop,
  .uuc_ports, .uuc_drop, .umc_ports, .umc_drop, .uvid_ports, .uvid_drop, .ipmc_ports,
  .ipmc_drop, .rate_period_tick);

// ---- test/sefc_top_tb.sv ----
/*
  Self-checking bench for sefc_top through its byte register port.
  Assumes shortened period counts of 16, 64 and 256 cycles.
*/
module sefc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  localparam logic [7:0] RA [19] = '{8'h7C, 8'h7D, 8'h7E, 8'h7F, 8'h80, 8'h81, 8'h82, 8'h83,
    8'h84, 8'h85, 8'h86, 8'h87, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h00};
  localparam logic [7:0] RV [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'hFA, 8'h88, 8'h80,
    8'h40, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10, 8'hA1, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  localparam logic [1:0] SPL [3] = '{2'h0, 2'h2, 2'h3};
  localparam logic [1:0] RSV [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  localparam logic EN [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [4:0] MAP [4] = '{5'h1F, 5'h00, 5'h0B, 5'h1F};
  localparam logic [7:0] PSEL [4] = '{8'h10, 8'h00, 8'h20, 8'h30};
  localparam int PER [4] = '{64, 16, 256, 256};
  logic clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, hi;
  logic power_event = 1'b0, prio_valid = 1'b0, frame_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [3:0] link_change = 4'h0, hits = 4'h0;
  logic [4:0] rule_filter_hit = 5'h00;
  logic [2:0] vlan_prio = 3'h0;
  logic [47:0] frame_da = 48'h0, frame_sa = 48'h0;
  wire [7:0] reg_rdata;
  wire irq, rule_filter_irq, queue_2q_high, self_drop, rate_period_tick;
  wire [1:0] queue_4q;
  wire [4:0] uuc_ports, umc_ports, uvid_ports, ipmc_ports;
  wire uuc_drop, umc_drop, uvid_drop, ipmc_drop;
  wire [19:0] all_ports = {ipmc_ports, uvid_ports, umc_ports, uuc_ports};
  wire [3:0] all_drop = {ipmc_drop, uvid_drop, umc_drop, uuc_drop};
  int errors = 0, cmp_count = 0, cycles = 0, i, k, n;

  sefc_top #(.CYC_16(32'h10), .CYC_64(32'h40), .CYC_256(32'h100)) uut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .link_change, .power_event, .rule_filter_hit, .vlan_prio, .prio_valid,
    .frame_da, .frame_sa, .frame_valid, .uuc_hit(hits[0]), .umc_hit(hits[1]),
    .uvid_hit(hits[2]), .ipmc_hit(hits[3]), .irq, .rule_filter_irq, .queue_4q,
    .queue_2q_high, .self_drop, .uuc_ports, .uuc_drop, .umc_ports, .umc_drop,
    .uvid_ports, .uvid_drop, .ipmc_ports, .ipmc_drop, .rate_period_tick);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: far above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask

  task automatic measure(output int gap);
    gap = 1;
    while (rate_period_tick !== 1'b1) @(negedge clk);
    @(negedge clk);
    while (rate_period_tick !== 1'b1) begin
      gap++;
      @(negedge clk);
    end
  endtask

  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    for (i = 0; i < 19; i++) begin
      rdchk(RA[i], RV[i]);
    end
    wr(8'h7E, 8'hFF);
    rdchk(8'h7E, 8'h00);
    wr(8'h7F, 8'hFF);
    rdchk(8'h7F, 8'h1F);
    wr(8'h7D, 8'hFF);
    rdchk(8'h7D, 8'h1F);
    for (i = 0; i < 5; i++) begin
      @(negedge clk);
      if (i < 4) link_change[i] = ~link_change[i];
      else power_event = 1'b1;
      repeat (6) @(negedge clk);
      check(irq, 1'b1);
      rdchk(8'h7C, 8'h01 << i);
      wr(8'h7C, 8'h01 << i);
      repeat (4) @(negedge clk);
      check(irq, 1'b0);
      rdchk(8'h7C, 8'h00);
    end
    wr(8'h7D, 8'h00);
    @(negedge clk);
    link_change[1] = ~link_change[1];
    repeat (6) @(negedge clk);
    check(irq, 1'b0);
    wr(8'h7D, 8'h02);
    repeat (4) @(negedge clk);
    check(irq, 1'b1);
    rule_filter_hit = 5'h15;
    repeat (5) @(negedge clk);
    rdchk(8'h7E, 8'h15);
    check(rule_filter_irq, 1'b1);
    wr(8'h7F, 8'h0A);
    repeat (4) @(negedge clk);
    check(rule_filter_irq, 1'b0);
    wr(8'h80, 8'hE4);
    wr(8'h81, 8'h1B);
    for (k = 0; k < 3; k++) begin
      wr(8'h82, {SPL[k], 6'h08});
      for (i = 0; i < 8; i++) begin
        @(negedge clk);
        vlan_prio = i[2:0];
        prio_valid = 1'b1;
        @(negedge clk);
        prio_valid = 1'b0;
        repeat (2) @(negedge clk);
        n = (i < 4) ? i : 7 - i;
        hi = n == 3 || (n == 2 && SPL[k] != 2'h0) || (n == 1 && SPL[k] == 2'h3);
        check(queue_4q, n[1:0]);
        check(queue_2q_high, hi);
      end
    end
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 4; i++) begin
        wr(8'(8'h83 + k), {RSV[k], EN[i], MAP[i]});
        @(negedge clk);
        hits[k] = 1'b1;
        @(negedge clk);
        hits[k] = 1'b0;
        check(all_ports[5*k +: 5], EN[i] ? MAP[i] : 5'h00);
        check(all_drop[k], !EN[i] || MAP[i] == 5'h00);
      end
    end
    wr(8'h86, 8'h40);
    for (i = 0; i < 3; i++) begin
      if (i == 2) wr(8'h86, 8'h00);
      @(negedge clk);
      frame_da = (i == 1) ? 48'h0010A1FFFFFE : 48'h0010A1FFFFFF;
      frame_valid = 1'b1;
      @(negedge clk);
      frame_valid = 1'b0;
      check(self_drop, i == 0);
    end
    for (k = 0; k < 4; k++) begin
      wr(8'h87, PSEL[k]);
      repeat (2) measure(n);
      check(n, PER[k]);
    end
    end_sim();
  end
endmodule
